// File: rtl/cmp_ctrl_map.svh
// register offsets, field positions and reset values of the comparator control
`ifndef CMP_CTRL_MAP_SVH
`define CMP_CTRL_MAP_SVH
`define ADDR_COMPARATOR_CONTROL 4'h0
`define ADDR_TIMER_LINK_CONTROL 4'h1
`define ADDR_PERIPHERAL_FLAG 4'h2
`define ADDR_PERIPHERAL_ENABLE 4'h3
`define ADDR_IRQ_CONTROL 4'h4
`define BIT_COMPARATOR_ON 7
`define BIT_COMPARATOR_RESULT 6
`define BIT_RESULT_PIN_ENABLE 5
`define BIT_RESULT_INVERT 4
`define BIT_NONINV_SOURCE 2
`define BIT_INV_CHANNEL 0
`define BIT_TIMER_GATE_SOURCE 1
`define BIT_RESULT_SYNC 0
`define BIT_CHANGE_FLAG 3
`define BIT_CHANGE_IRQ_ENABLE 3
`define BIT_GLOBAL_IRQ_ENABLE 7
`define BIT_PERIPHERAL_IRQ_ENABLE 6
`define CONTROL_WRITE_MASK 8'hB5
`define CONTROL_RESET 8'h00
`define TIMER_LINK_WRITE_MASK 8'h03
`define TIMER_LINK_RESET 8'h02
`define FLAG_WRITE_MASK 8'h08
`define IRQ_CONTROL_WRITE_MASK 8'hC0
`define QUARTER_COUNT 2'h3
`endif

// File: rtl/cmp_ctrl_pkg.sv
// types shared by the comparator control block
package cmp_ctrl_pkg;
	typedef enum logic [1:0] {quarter_one, quarter_two, quarter_three,
		quarter_four} quarter_e;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;
	typedef struct packed {
		logic [7:0] control;
		logic [7:0] timer_link;
		logic change_flag;
		logic change_irq_enable;
		logic global_irq_enable;
		logic peripheral_irq_enable;
		quarter_e quarter;
		logic result;
		logic read_latch;
		logic sample_latch;
		logic mismatch_d;
		logic sync_result;
		logic timer_clk_d;
		logic [7:0] rdata;
		logic pin_out;
		logic pin_oe;
		logic irq;
		logic wake;
		logic timer_gate;
		logic inv_channel;
		logic noninv_source;
		logic analog_on;
	} state_s;
endpackage

// File: rtl/comparator_control.sv
// comparator control, output routing, change detect and timer gate
// Behaviour
// - comparator runs only while enable bit 7 is one
// - bit 0 picks inverting pin a (zero) or pin b (one)
// - bit 2 picks internal reference (one) or noninverting pin (zero)
// - bit 4 inverts the reported result
// - bit 6 is read-only registered result; pin is driven from the live value, not that result
// - pin driven whenever direction bit zero, whatever pin enable and comparator on
// - pin enable overrides port data latch regardless of comparator enable
// - internal result registered once per instruction cycle
// - read latch captures result on each control register read
// - sample latch takes result every quarter one; xor forms mismatch
// - mismatch holds until control read or result returns
// - control write also clears mismatch via internal read
// - change flag set on mismatch rising edge only
// - software clears flag writing zero, may set it writing one
// - irq needs all three enables; flag sets regardless
// - change coinciding with control read may miss the flag
// - enabled comparator keeps running in sleep
// - change wakes device when change and peripheral enables set
// - reset returns control register to off state
// - gate source zero lets result gate the timer
// - port reads return zero on analog-selected pins
// - sync latches result on falling edge of prescaled timer clock
`include "cmp_ctrl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module comparator_control
	import cmp_ctrl_pkg::*;
#(
	parameter int PORT_WIDTH = 6
)(
	input wire logic clock,
	input wire logic srst,
	input wire reg_req_s req,
	output logic [7:0] rdata,
	input wire logic analog_compare,
	input wire logic pin_direction_bit,
	input wire logic port_data_latch,
	input wire logic timer_clock,
	input wire logic timer_running,
	input wire logic timer_gate_enable,
	input wire logic [PORT_WIDTH-1:0] port_pins,
	input wire logic [PORT_WIDTH-1:0] analog_select_reg,
	input wire logic port_read,
	output logic [PORT_WIDTH-1:0] port_rdata,
	output logic pin_out,
	output logic pin_oe,
	output logic irq,
	output logic wake,
	output logic timer_gate,
	output logic inv_channel_select,
	output logic noninv_source_select,
	output logic comparator_on
);
	state_s s;
	state_s next_s;
	logic [PORT_WIDTH-1:0] port_q;
	logic polar;
	logic live;
	logic ctrl_read;
	logic [7:0] wmask;

	// masked register write keeping read-only bits
	function automatic logic [7:0] merge(input logic [7:0] old,
		input logic [7:0] din, input logic [7:0] mask);
		merge = (old & ~mask) | (din & mask);
	endfunction

	// polarity-adjusted result, zero while comparator off
	assign polar = analog_compare ^ s.control[`BIT_RESULT_INVERT];
	assign live = s.control[`BIT_COMPARATOR_ON] & polar;
	// every control register write starts with an internal read of the control register
	assign ctrl_read = (req.rd | req.wr)
		&& req.addr == `ADDR_COMPARATOR_CONTROL;
	assign wmask = `CONTROL_WRITE_MASK;

	// next state
	always_comb
	begin
		logic mismatch;
		logic set_evt;
		mismatch = 1'b0;
		set_evt = 1'b0;
		next_s = s;
		next_s.quarter = quarter_e'(s.quarter + 2'h1);
		if (s.quarter == quarter_four)
		begin
			next_s.result = live;
		end
		if (s.quarter == quarter_one)
		begin
			next_s.sample_latch = s.result;
		end
		// a read at quarter one may race a change and miss the flag
		if (ctrl_read)
		begin
			next_s.read_latch = s.result;
		end
		mismatch = s.read_latch ^ s.sample_latch;
		next_s.mismatch_d = mismatch;
		set_evt = mismatch & ~s.mismatch_d;
		// falling edge of prescaled timer clock latches the result
		next_s.timer_clk_d = timer_clock;
		if (s.timer_clk_d & ~timer_clock)
		begin
			next_s.sync_result = s.result;
		end
		next_s.rdata = 8'h00;
		if (req.rd)
		begin
			case (req.addr)
				`ADDR_COMPARATOR_CONTROL:
				begin
					next_s.rdata = s.control;
					next_s.rdata[`BIT_COMPARATOR_RESULT] = s.result;
				end
				`ADDR_TIMER_LINK_CONTROL:
				begin
					next_s.rdata = s.timer_link;
				end
				`ADDR_PERIPHERAL_FLAG:
				begin
					next_s.rdata[`BIT_CHANGE_FLAG] = s.change_flag;
				end
				`ADDR_PERIPHERAL_ENABLE:
				begin
					next_s.rdata[`BIT_CHANGE_IRQ_ENABLE] = s.change_irq_enable;
				end
				`ADDR_IRQ_CONTROL:
				begin
					next_s.rdata[`BIT_GLOBAL_IRQ_ENABLE] = s.global_irq_enable;
					next_s.rdata[`BIT_PERIPHERAL_IRQ_ENABLE] =
						s.peripheral_irq_enable;
				end
				default:
				begin
					next_s.rdata = 8'h00;
				end
			endcase
		end
		if (req.wr)
		begin
			case (req.addr)
				`ADDR_COMPARATOR_CONTROL:
				begin
					next_s.control = merge(s.control, req.wdata, wmask);
				end
				`ADDR_TIMER_LINK_CONTROL:
				begin
					next_s.timer_link = merge(s.timer_link, req.wdata,
						`TIMER_LINK_WRITE_MASK);
				end
				`ADDR_PERIPHERAL_FLAG:
				begin
					next_s.change_flag = req.wdata[`BIT_CHANGE_FLAG];
				end
				`ADDR_PERIPHERAL_ENABLE:
				begin
					next_s.change_irq_enable = req.wdata[`BIT_CHANGE_IRQ_ENABLE];
				end
				`ADDR_IRQ_CONTROL:
				begin
					next_s.global_irq_enable = req.wdata[`BIT_GLOBAL_IRQ_ENABLE];
					next_s.peripheral_irq_enable =
						req.wdata[`BIT_PERIPHERAL_IRQ_ENABLE];
				end
				default:
				begin
					next_s.control = s.control;
				end
			endcase
		end
		// hardware set wins over a software clear in the same cycle
		if (set_evt)
		begin
			next_s.change_flag = 1'b1;
		end
		next_s.irq = next_s.change_flag & next_s.change_irq_enable
			& next_s.peripheral_irq_enable
			& next_s.global_irq_enable;
		next_s.wake = next_s.change_flag & next_s.change_irq_enable
			& next_s.peripheral_irq_enable;
		// pin enable overrides the port latch; on-bit gates only the value
		next_s.pin_oe = ~pin_direction_bit;
		next_s.pin_out = next_s.control[`BIT_RESULT_PIN_ENABLE]
			? live : port_data_latch;
		next_s.timer_gate = (~s.timer_link[`BIT_TIMER_GATE_SOURCE])
			& timer_running & timer_gate_enable
			& (s.timer_link[`BIT_RESULT_SYNC]
			? s.sync_result : s.result);
		next_s.inv_channel = next_s.control[`BIT_INV_CHANNEL];
		next_s.noninv_source = next_s.control[`BIT_NONINV_SOURCE];
		next_s.analog_on = next_s.control[`BIT_COMPARATOR_ON];
	end

	// state register; reset leaves comparator and reference off
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			s <= '0;
			s.control <= `CONTROL_RESET;
			s.timer_link <= `TIMER_LINK_RESET;
		end
		else
		begin
			s <= next_s;
		end
	end

	// port read path, analog pins read zero
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			port_q <= '0;
		end
		else if (port_read)
		begin
			port_q <= port_pins & ~analog_select_reg;
		end
		else
		begin
			port_q <= '0;
		end
	end

	assign port_rdata = port_q;
	assign rdata = s.rdata;
	assign pin_out = s.pin_out;
	assign pin_oe = s.pin_oe;
	assign irq = s.irq;
	assign wake = s.wake;
	assign timer_gate = s.timer_gate;
	assign inv_channel_select = s.inv_channel;
	assign noninv_source_select = s.noninv_source;
	assign comparator_on = s.analog_on;
endmodule
`default_nettype wire

// File: tb/analog_core_model.sv
// behavioural analog comparator core behind the control block
`timescale 1ns/1ps
`default_nettype none
module analog_core_model (
	input wire logic comparator_on,
	input wire logic inv_channel_select,
	input wire logic noninv_source_select,
	input wire logic [31:0] levels,
	output logic analog_compare
);
	logic [7:0] inv_v;
	logic [7:0] noninv_v;
	// levels hold pin a, pin b, noninverting pin, reference
	assign inv_v = inv_channel_select ? levels[23:16] : levels[31:24];
	assign noninv_v = noninv_source_select ? levels[7:0] : levels[15:8];
	// a switched-off core reads low, not a stale level
	assign analog_compare = comparator_on && (noninv_v > inv_v);
endmodule
`default_nettype wire

// File: tb/cmp_ctrl_properties.sv
// port assertions for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module cmp_ctrl_checker
	import cmp_ctrl_pkg::*;
#(
	parameter int PORT_WIDTH = 6
)(
	input wire logic clock,
	input wire logic srst,
	input wire reg_req_s req,
	input wire logic [7:0] rdata,
	input wire logic port_data_latch,
	input wire logic timer_running,
	input wire logic timer_gate_enable,
	input wire logic [PORT_WIDTH-1:0] port_pins,
	input wire logic [PORT_WIDTH-1:0] analog_select_reg,
	input wire logic port_read,
	input wire logic [PORT_WIDTH-1:0] port_rdata,
	input wire logic pin_out,
	input wire logic irq,
	input wire logic wake,
	input wire logic timer_gate,
	input wire logic inv_channel_select,
	input wire logic noninv_source_select,
	input wire logic comparator_on
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	logic [3:0] shadow;
	// shadow of pin enable, enable, reference and channel bits
	always_ff @(posedge clock)
	begin
		if (srst)
			shadow <= 4'h0;
		else if (req.wr && req.addr == 4'h0)
			shadow <= {req.wdata[5], req.wdata[7], req.wdata[2], req.wdata[0]};
	end
	sequence ctl_wr;
		req.wr && req.addr == 4'h0;
	endsequence
	sequence ctl_set;
		ctl_wr ##1 (!req.wr) [*2];
	endsequence
	chk_reserved_read_zero: assert property (
		req.rd && req.addr == 4'h0 |=> !rdata[3] && !rdata[1])
		else $error("reserved control bit read high");
	chk_enable_copy: assert property (
		ctl_set |-> comparator_on == shadow[2])
		else $error("enable output differs from written bit");
	chk_channel_copy: assert property (
		ctl_set |-> inv_channel_select == shadow[0])
		else $error("channel select differs from written bit");
	chk_reference_copy: assert property (
		ctl_set |-> noninv_source_select == shadow[1])
		else $error("reference select differs from written bit");
	chk_pin_port_latch: assert property (
		!shadow[3] && !(req.wr && req.addr == 4'h0 && req.wdata[5])
		|=> pin_out == $past(port_data_latch))
		else $error("pin does not follow port latch");
	chk_port_analog_zero: assert property (
		port_read |=> port_rdata == $past(port_pins & ~analog_select_reg))
		else $error("analog pin read not zero");
	chk_port_idle_zero: assert property (
		!port_read |=> port_rdata == '0)
		else $error("port data without a read");
	chk_gate_needs_timer: assert property (
		timer_gate |-> $past(timer_running) && $past(timer_gate_enable))
		else $error("gate open while timer idle");
	chk_irq_needs_wake: assert property (
		irq |-> wake)
		else $error("interrupt without wake condition");
endmodule
bind comparator_control cmp_ctrl_checker #(.PORT_WIDTH(PORT_WIDTH)) i_chk (
	.clock(clock), .srst(srst), .req(req), .rdata(rdata),
	.port_data_latch(port_data_latch), .timer_running(timer_running),
	.timer_gate_enable(timer_gate_enable), .port_pins(port_pins),
	.analog_select_reg(analog_select_reg), .port_read(port_read),
	.port_rdata(port_rdata), .pin_out(pin_out), .irq(irq), .wake(wake),
	.timer_gate(timer_gate), .inv_channel_select(inv_channel_select),
	.noninv_source_select(noninv_source_select),
	.comparator_on(comparator_on));
`default_nettype wire

// File: tb/tb_top.sv
// register-level bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import cmp_ctrl_pkg::*;
	logic clock, srst, port_read, dir, latch, tclk, run, gen, cmp;
	reg_req_s req;
	logic [7:0] rdata;
	logic [31:0] levels;
	logic [5:0] pins, asel, prd;
	logic pin_out, pin_oe, irq, wake, gate, inv_sel, ref_sel, on;
	int bad_count, checked;
	comparator_control i_dut (.clock(clock), .srst(srst), .req(req),
		.rdata(rdata), .analog_compare(cmp), .pin_direction_bit(dir),
		.port_data_latch(latch), .timer_clock(tclk), .timer_running(run),
		.timer_gate_enable(gen), .port_pins(pins), .analog_select_reg(asel),
		.port_read(port_read), .port_rdata(prd), .pin_out(pin_out),
		.pin_oe(pin_oe), .irq(irq), .wake(wake), .timer_gate(gate),
		.inv_channel_select(inv_sel), .noninv_source_select(ref_sel),
		.comparator_on(on));
	analog_core_model i_core (.comparator_on(on), .inv_channel_select(inv_sel),
		.noninv_source_select(ref_sel), .levels(levels), .analog_compare(cmp));
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// slow timer clock
	always @(posedge clock)
		tclk <= ~tclk;
	task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock) req <= '{a, d, 1'b1, 1'b0};
		@(posedge clock) req <= '0;
	endtask
	task rd(input string name, input logic [3:0] a, input logic [7:0] e);
		@(posedge clock) req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clock) req <= '0;
		#1 chk(name, rdata, e);
	endtask
	task tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// watchdog
	initial
	begin
		#100us;
		bad_count++;
		summarize();
	end
	initial
	begin
		srst = 1'b1; req = '0; port_read = 1'b0; dir = 1'b0; latch = 1'b0;
		tclk = 1'b0; run = 1'b1; gen = 1'b1; pins = 6'h3F; asel = 6'h05;
		levels = 32'h40203050; bad_count = 0; checked = 0;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		rd("control", 4'h0, 8'h00);
		rd("link", 4'h1, 8'h02);
		wr(4'h0, 8'hFF);
		tick(8);
		chk("selects", {5'h00, on, ref_sel, inv_sel}, 8'h07);
		rd("control", 4'h0, 8'hB5);
		chk("pin", {7'h00, pin_out}, 8'h00);
		wr(4'h0, 8'hA5);
		tick(8);
		rd("control", 4'h0, 8'hE5);
		chk("pin", {7'h00, pin_out}, 8'h01);
		wr(4'h0, 8'h85);
		wr(4'h3, 8'h08);
		wr(4'h4, 8'hC0);
		rd("control", 4'h0, 8'hC5);
		tick(8);
		wr(4'h2, 8'h00);
		@(posedge clock) levels[7:0] <= 8'h10;
		tick(12);
		chk("irq", {6'h00, irq, wake}, 8'h03);
		rd("flag", 4'h2, 8'h08);
		wr(4'h2, 8'h00);
		tick(8);
		chk("irq", {7'h00, irq}, 8'h00);
		rd("control", 4'h0, 8'h85);
		wr(4'h2, 8'h08);
		tick(2);
		chk("irq", {7'h00, irq}, 8'h01);
		wr(4'h4, 8'h40);
		tick(2);
		chk("irq", {6'h00, irq, wake}, 8'h01);
		@(posedge clock) port_read <= 1'b1;
		@(posedge clock) port_read <= 1'b0;
		#1 chk("port", {2'h0, prd}, 8'h3A);
		chk("oe", {7'h00, pin_oe}, 8'h01);
		@(posedge clock) dir <= 1'b1;
		tick(2);
		chk("oe", {7'h00, pin_oe}, 8'h00);
		@(posedge clock) dir <= 1'b0;
		wr(4'h1, 8'h00);
		@(posedge clock) levels[7:0] <= 8'h50;
		tick(8);
		chk("gate", {7'h00, gate}, 8'h01);
		@(posedge clock) gen <= 1'b0;
		tick(2);
		chk("gate", {7'h00, gate}, 8'h00);
		// synchronised gate source follows the falling timer clock edge
		@(posedge clock) gen <= 1'b1;
		wr(4'h1, 8'h01);
		tick(8);
		chk("sync gate", {7'h00, gate}, 8'h01);
		@(posedge clock) levels[7:0] <= 8'h10;
		tick(10);
		chk("sync gate", {7'h00, gate}, 8'h00);
		@(posedge clock) srst <= 1'b1;
		@(posedge clock) srst <= 1'b0;
		rd("control", 4'h0, 8'h00);
		summarize();
	end
endmodule
`default_nettype wire
